/* File: bench/risc_host_model.sv */
// Host model that programs the nominal frequency of every input index.
// Assumes one write per cycle is accepted; entry i gets base plus i.
`timescale 1ns/10ps
module risc_host_model
   import risc_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic go,
   input wire logic [FREQ_M_W-1:0] baseNum,
   input wire logic [FREQ_N_W-1:0] baseDen,
   output logic freqWrite,
   output logic [IDX_W-1:0] freqIndex,
   output logic [FREQ_M_W-1:0] freqNum,
   output logic [FREQ_N_W-1:0] freqDen,
   output logic done
);
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         freqWrite <= 1'b0;
         freqIndex <= 4'h0;
         freqNum <= 48'h0;
         freqDen <= 16'h0;
         done <= 1'b0;
      end else if (go && !freqWrite && !done) begin
         freqWrite <= 1'b1;
         freqIndex <= 4'h0;
         freqNum <= baseNum;
         freqDen <= baseDen;
      end else if (freqWrite && freqIndex == 4'hF) begin
         // Released number and denominator lines flip so a stale value cannot pass for data
         freqWrite <= 1'b0;
         freqNum <= ~freqNum;
         freqDen <= ~freqDen;
         done <= 1'b1;
      end else if (freqWrite) begin
         freqIndex <= freqIndex + 4'h1;
         freqNum <= freqNum + 48'h1;
         freqDen <= freqDen + 16'h1;
      end
   end
endmodule

/* File: bench/risc_ref_input_cfg_props.sv */
// Port-level assertions for the reference input configuration block.
// Assumes boot images hold steady while loading; bound to every instance of the block.
`timescale 1ns/10ps
module risc_ref_input_cfg_props
   import risc_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [2*NUM_STAGES-1:0] stageMode,
   input wire logic [NUM_STAGES-1:0] stageNmos,
   input wire logic [NUM_CLKS-1:0] clkEnable,
   input wire logic [NUM_CLKS-1:0] clkIsPulse,
   input wire logic freqWrite,
   input wire logic [IDX_W-1:0] freqIndex,
   input wire logic otpEnable,
   input wire logic otpValid,
   input wire logic [FBDIV_W-1:0] otpFbDiv,
   input wire logic pllWrite,
   input wire logic [FBDIV_W-1:0] pllFbDivIn,
   input wire logic pllDoublerIn,
   input wire logic [VCV_W-1:0] ctrlVoltage,
   input wire logic lolGpioEnable,
   input wire logic [FBDIV_W-1:0] pllFbDiv,
   input wire logic pllDoubler,
   input wire logic pllWriteRejected,
   input wire logic bootDone,
   input wire logic lossOfLock,
   input wire logic lolGpio,
   input wire logic [NUM_CLKS-1:0] freqProgrammed,
   input wire logic [NUM_CLKS-1:0] stageNmosActive,
   input wire logic [NUM_CLKS-1:0] refClk,
   input wire logic [NUM_CLKS-1:0] pulseOut
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [NUM_CLKS-1:0] nmosExp;
   logic fbInRange;
   assign fbInRange = pllFbDivIn >= FBDIV_MIN && pllFbDivIn <= FBDIV_MAX;
   // Buffer type only counts where a differential pair exists
   always_comb begin
      nmosExp = 16'h0000;
      for (int s = 0; s < NUM_STAGES; s++) begin
         nmosExp[s] = stageNmos[s] && (stageMode[2*s +: 2] == 2'h0 || stageMode[2*s +: 2] == 2'h2);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   fb_range_a: assert property (pllFbDiv >= FBDIV_MIN && pllFbDiv <= FBDIV_MAX)
      else $error("feedback divider left its legal range");
   wr_reject_a: assert property (pllWrite && bootDone && !fbInRange |=> pllWriteRejected && $stable(pllFbDiv))
      else $error("out of range divider write not refused");
   wr_accept_a: assert property (pllWrite && bootDone && fbInRange |=> !pllWriteRejected && pllFbDiv == $past(pllFbDivIn)
      && pllDoubler == $past(pllDoublerIn))
      else $error("legal divider write not applied");
   boot_otp_a: assert property ($rose(bootDone) && otpEnable && otpValid |-> pllFbDiv == otpFbDiv)
      else $error("boot image not taken from OTP");
   lol_gpio_a: assert property ($past(arst_n) |-> lolGpio == $past(lolGpioEnable && lossOfLock))
      else $error("lock alarm pin does not follow alarm");
   lock_in_a: assert property (ctrlVoltage >= 8'h30 && ctrlVoltage <= 8'hC0 |=> !lossOfLock)
      else $error("alarm raised with voltage mid band");
   lock_out_a: assert property (ctrlVoltage < VCV_BASE_LO |=> lossOfLock)
      else $error("alarm missing with voltage below band");
   nmos_mode_a: assert property ($past(arst_n) |-> stageNmosActive == $past(nmosExp))
      else $error("buffer type active in wrong mode");
   freq_flag_a: assert property (freqWrite |=> freqProgrammed[$past(freqIndex)])
      else $error("frequency entry not flagged");
   off_quiet_a: assert property ((clkEnable == 16'h0000) [*3] |-> (refClk | pulseOut) == 16'h0000)
      else $error("disabled path still active");
   pulse_role_a: assert property ((clkIsPulse == 16'hFFFF) [*3] |-> refClk == 16'h0000)
      else $error("pulse role path drives clock output");
   cover property (pllWriteRejected);
   cover property ($rose(bootDone));
   cover property (lolGpio);
endmodule
bind risc_ref_input_cfg risc_ref_input_cfg_props u_props (.core_clk, .arst_n, .stageMode, .stageNmos, .clkEnable,
   .clkIsPulse, .freqWrite, .freqIndex, .otpEnable, .otpValid, .otpFbDiv, .pllWrite, .pllFbDivIn, .pllDoublerIn,
   .ctrlVoltage, .lolGpioEnable, .pllFbDiv, .pllDoubler, .pllWriteRejected, .bootDone, .lossOfLock, .lolGpio,
   .freqProgrammed, .stageNmosActive, .refClk, .pulseOut);

/* File: bench/test_reference_input_stage_config.sv */
// Self-checking bench for the reference input configuration block.
// Assumes the host model and checker files are compiled alongside.
`timescale 1ns/10ps
module test_reference_input_stage_config;
   import risc_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [NUM_STAGES-1:0] stagePosPin, stageNegPin, stageNmos;
   logic gpio0RefIn, gpio3RefIn, otpEnable, otpValid, otpDoubler, eepromEnable, eepromValid, eepromDoubler;
   logic pllWrite, pllDoublerIn, lolGpioEnable, hostGo, hostDone, freqWrite, expDb;
   logic pllDoubler, pllWriteRejected, bootDone, lossOfLock, lolGpio;
   logic [2*NUM_STAGES-1:0] stageMode;
   logic [NUM_CLKS-1:0] clkEnable, clkInvert, clkBypass, clkIsPulse, freqProgrammed, stageNmosActive, refClk, pulseOut;
   logic [NUM_CLKS*PDIV_W-1:0] clkDivValue;
   logic [IDX_W-1:0] freqIndex, freqReadIndex;
   logic [FREQ_M_W-1:0] freqNum, freqNumRead, baseNum;
   logic [FREQ_N_W-1:0] freqDen, freqDenRead, baseDen;
   logic [FBDIV_W-1:0] otpFbDiv, eepromFbDiv, pllFbDivIn, pllFbDiv, expFb;
   logic [VCV_W-1:0] ctrlVoltage;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;
   int seed = 32'hD471DBB4;
   ////////////////////////////////////////////////////////////////////////////////
   risc_ref_input_cfg u_dut (.core_clk, .arst_n, .stagePosPin, .stageNegPin, .gpio0RefIn, .gpio3RefIn, .stageMode,
      .stageNmos, .clkEnable, .clkInvert, .clkBypass, .clkDivValue, .clkIsPulse, .freqWrite, .freqIndex, .freqNum,
      .freqDen, .freqReadIndex, .freqNumRead, .freqDenRead, .freqProgrammed, .otpEnable, .otpValid, .otpFbDiv,
      .otpDoubler, .eepromEnable, .eepromValid, .eepromFbDiv, .eepromDoubler, .pllWrite, .pllFbDivIn, .pllDoublerIn,
      .ctrlVoltage, .lolGpioEnable, .pllFbDiv, .pllDoubler, .pllWriteRejected, .bootDone, .lossOfLock, .lolGpio,
      .stageNmosActive, .refClk, .pulseOut);
   risc_host_model u_host (.core_clk, .arst_n, .go(hostGo), .baseNum, .baseDen, .freqWrite, .freqIndex, .freqNum,
      .freqDen, .done(hostDone));
   ////////////////////////////////////////////////////////////////////////////////
   always #20 core_clk = ~core_clk;
   // Lock voltage and alarm pin enable wander all run long
   always @(posedge core_clk) begin
      cycles++;
      ctrlVoltage <= 8'($random(seed));
      lolGpioEnable <= 1'($random(seed));
      if (cycles == 20000) begin
         fails++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      if (fails == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Source level of each internal clock before inversion, plus which ones have a source
   function automatic logic [15:0] expRef(input logic [13:0] md, input logic [6:0] p, input logic [6:0] n,
      input logic g0, input logic g3, output logic [15:0] mk);
      logic [15:0] ex;
      ex = {g3, 15'h0000};
      mk = 16'h8000;
      for (int s = 0; s < NUM_STAGES; s++) begin
         if (md[2*s +: 2] != 2'h3) begin
            ex[s] = md[2*s +: 2] == 2'h1 ? p[s] : p[s] & ~n[s];
            mk[s] = 1'b1;
         end
         if (md[2*s +: 2] == 2'h1 || md[2*s +: 2] == 2'h2) begin
            ex[s+8] = md[2*s +: 2] == 2'h1 ? n[s] : g0;
            mk[s+8] = 1'b1;
         end
      end
      return ex;
   endfunction
   task automatic do_reset(input logic useOtp);
      arst_n <= 1'b0;
      otpValid <= useOtp;
      otpFbDiv <= 10'(122 + $unsigned($random(seed)) % 439);
      eepromFbDiv <= 10'(122 + $unsigned($random(seed)) % 439);
      otpDoubler <= 1'($random(seed));
      eepromDoubler <= 1'($random(seed));
      repeat (8) @(posedge core_clk);
      chk({pllFbDiv, lossOfLock, bootDone, freqProgrammed}, {FBDIV_RESET, 2'h2, 16'h0000});
      expFb = useOtp ? otpFbDiv : eepromFbDiv;
      expDb = useOtp ? otpDoubler : eepromDoubler;
      arst_n <= 1'b1;
      pllWrite <= 1'b1;
      pllFbDivIn <= 10'h0C8;
      @(posedge core_clk);
      pllWrite <= 1'b0;
      for (int i = 0; i < 20 && bootDone !== 1'b1; i++) begin
         @(posedge core_clk);
      end
      chk({bootDone, pllFbDiv, pllDoubler}, {1'b1, expFb, expDb});
   endtask
   task automatic pll_wr(input logic [9:0] v);
      logic ok;
      ok = v >= FBDIV_MIN && v <= FBDIV_MAX;
      pllWrite <= 1'b1;
      pllFbDivIn <= v;
      pllDoublerIn <= 1'($random(seed));
      @(posedge core_clk);
      pllWrite <= 1'b0;
      if (ok) begin
         expFb = v;
         expDb = pllDoublerIn;
      end
      @(posedge core_clk);
      chk({pllWriteRejected, pllFbDiv, pllDoubler}, {~ok, expFb, expDb});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [13:0] md;
      logic [15:0] en, inv, pul, ex, mk;
      logic [6:0] p, n;
      logic g0, g3, last;
      int cnt, dv;
      {stagePosPin, stageNegPin, stageNmos, stageMode} = '0;
      {gpio0RefIn, gpio3RefIn, otpDoubler, eepromDoubler, pllWrite, pllDoublerIn, hostGo} = '0;
      {clkEnable, clkInvert, clkBypass, clkIsPulse, clkDivValue, freqReadIndex} = '0;
      {baseNum, baseDen, otpFbDiv, eepromFbDiv, pllFbDivIn} = '0;
      otpEnable = 1'b1;
      otpValid = 1'b1;
      eepromEnable = 1'b1;
      eepromValid = 1'b1;
      do_reset(1'b1);
      pll_wr(10'h000);
      pll_wr(10'h3FF);
      pll_wr(10'h079);
      pll_wr(10'h07A);
      pll_wr(10'h230);
      pll_wr(10'h231);
      repeat (10) pll_wr(10'($random(seed)));
      // Bypassed paths: random modes, pins, polarity, enables and roles
      for (int i = 0; i < 24; i++) begin
         md = 14'($random(seed)) & 14'h1555;
         if ($random(seed) & 1) md[1:0] = 2'h2;
         if (i == 2) md[13:12] = 2'h3;
         {p, n, g0, g3} = 16'($random(seed));
         en = i == 1 ? 16'h0000 : 16'($random(seed));
         inv = 16'($random(seed));
         pul = i == 0 ? 16'hFFFF : 16'($random(seed));
         ex = expRef(md, p, n, g0, g3, mk);
         {stageMode, stagePosPin, stageNegPin, gpio0RefIn, gpio3RefIn} <= {md, p, n, g0, g3};
         {clkEnable, clkInvert, clkIsPulse} <= {en, inv, pul};
         clkBypass <= md[1:0] == 2'h2 ? 16'h7EFF : 16'h7FFF;
         clkDivValue <= {$random(seed), $random(seed)};
         stageNmos <= 7'($random(seed));
         repeat (5) @(posedge core_clk);
         ex = (ex ^ inv) & en & mk;
         chk(refClk, ex & ~pul);
         chk(pulseOut, ex & pul);
      end
      // Divided path on clock 1: output rises once per N input rises
      for (int i = 0; i < 3; i++) begin
         dv = i == 0 ? 2 : i == 1 ? 15 : 2 + $unsigned($random(seed)) % 14;
         {stageMode, clkEnable, clkBypass, clkInvert, clkIsPulse} <= {14'h0000, 16'h0002, 48'h0};
         clkDivValue <= {16{4'(dv)}};
         cnt = 0;
         last = 1'b0;
         for (int k = 0; k < 32 * dv; k++) begin
            stagePosPin[1] <= k[0];
            stageNegPin[1] <= ~k[0];
            @(posedge core_clk);
            if (k >= 16 * dv && refClk[1] === 1'b1 && last === 1'b0) cnt++;
            last = refClk[1];
         end
         chk(cnt >= 7 && cnt <= 9, 1'b1);
      end
      // Host programs every index, then each entry is read back
      baseNum <= {16'($random(seed)), 32'($random(seed))};
      baseDen <= 16'($random(seed));
      hostGo <= 1'b1;
      for (int k = 0; k < 40 && hostDone !== 1'b1; k++) begin
         @(posedge core_clk);
      end
      hostGo <= 1'b0;
      for (int k = 0; k < NUM_CLKS; k++) begin
         freqReadIndex <= 4'(k);
         repeat (2) @(posedge core_clk);
         chk({freqNumRead, freqDenRead}, {baseNum + 48'(k), baseDen + 16'(k)});
      end
      chk(freqProgrammed, 16'hFFFF);
      do_reset(1'b0);
      pll_wr(10'h0C8);
      wrap_up();
   end
endmodule

/* File: rtl/risc_lock_mon.sv */
// System PLL lock monitor: limits derived from the feedback divider and doubler setting.
// Assumes the loop filter control voltage arrives as a digitised word on core_clk.
`timescale 1ns/10ps
module risc_lock_mon
   import risc_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [VCV_W-1:0] ctrlVoltage,
   input wire logic [FBDIV_W-1:0] fbDiv,
   input wire logic doubler,
   output logic lossOfLock
);
   logic [VCV_W-1:0] limLo;
   logic [VCV_W-1:0] limHi;
   logic [VCV_W-1:0] span;
   logic next_lossOfLock;

   ////////////////////////////////////////////////////////////////////////
   // Window narrows slightly at high multiplication; no user threshold exists
   assign span = VCV_SPAN_STEP + VCV_W'(fbDiv[FBDIV_W-1:FBDIV_W-3]) + VCV_W'(doubler);
   assign limLo = VCV_BASE_LO + span;
   assign limHi = VCV_BASE_HI - span;

   always_comb begin
      next_lossOfLock = (ctrlVoltage < limLo) || (ctrlVoltage > limHi);
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         lossOfLock <= 1'b1;
      end else begin
         lossOfLock <= next_lossOfLock;
      end
   end
endmodule

/* File: rtl/risc_pkg.sv */
// Shared constants for the reference input stage and system PLL configuration block.
// Assumes a single core clock domain; no register bus, all controls are plain ports.
package risc_pkg;
   localparam int NUM_STAGES = 7;
   localparam int NUM_CLKS = 16;
   localparam int IDX_W = 4;
   localparam int NEG_OFFSET = 8;
   localparam int FREQ_M_W = 48;
   localparam int FREQ_N_W = 16;
   localparam int FBDIV_W = 10;
   localparam logic [FBDIV_W-1:0] FBDIV_MIN = 10'h07A;
   localparam logic [FBDIV_W-1:0] FBDIV_MAX = 10'h230;
   localparam logic [FBDIV_W-1:0] FBDIV_RESET = 10'h07A;
   localparam int PDIV_W = 4;
   localparam logic [PDIV_W-1:0] PDIV_MIN = 4'h2;
   localparam logic [PDIV_W-1:0] PDIV_MAX = 4'hF;
   localparam logic [PDIV_W-1:0] PDIV_ONE = 4'h1;
   localparam logic [PDIV_W-1:0] PDIV_ZERO = 4'h0;
   localparam int GPIO0_STAGE = 0;
   localparam int GPIO0_CLK = 8;
   localparam int GPIO3_CLK = 15;
   localparam int VCV_W = 8;
   localparam logic [VCV_W-1:0] VCV_BASE_LO = 8'h20;
   localparam logic [VCV_W-1:0] VCV_BASE_HI = 8'hE0;
   localparam logic [VCV_W-1:0] VCV_SPAN_STEP = 8'h01;
   localparam int LOAD_STEPS = 4;
   localparam logic [2:0] LOAD_CNT_W0 = 3'h0;

   typedef enum logic [1:0] {
      RISC_MODE_DIFF = 2'h0,
      RISC_MODE_DUAL_SE = 2'h1,
      RISC_MODE_DIFF_GPIO = 2'h2
   } risc_mode_e;

   typedef enum logic [3:0] {
      RISC_ST_IDLE = 4'h1,
      RISC_ST_LOAD = 4'h2,
      RISC_ST_DONE = 4'h4,
      RISC_ST_RUN = 4'h8
   } risc_state_e;
endpackage

/* File: rtl/risc_pre_div.sv */
// One reference path: optional inversion, disable, and integer pre-divider 2..15 with bypass.
// Assumes the reference is sampled synchronously to core_clk.
`timescale 1ns/10ps
module risc_pre_div
   import risc_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic refIn,
   input wire logic enable,
   input wire logic invert,
   input wire logic bypass,
   input wire logic [PDIV_W-1:0] divValue,
   output logic refOut
);
   logic polIn;
   logic prevIn;
   logic next_prevIn;
   logic [PDIV_W-1:0] count;
   logic [PDIV_W-1:0] next_count;
   logic divClk;
   logic next_divClk;
   logic next_refOut;
   logic [PDIV_W-1:0] divSafe;

   ////////////////////////////////////////////////////////////////////////
   assign polIn = refIn ^ invert;
   // Out-of-range settings clamp so the divider never stalls
   assign divSafe = (divValue < PDIV_MIN) ? PDIV_MIN : divValue;

   always_comb begin
      next_prevIn = polIn;
      next_count = count;
      next_divClk = divClk;
      if (!enable) begin
         next_count = PDIV_ZERO;
         next_divClk = 1'b0;
      end else if (polIn && !prevIn) begin
         if (count >= divSafe - PDIV_ONE) begin
            next_count = PDIV_ZERO;
            next_divClk = 1'b1;
         end else begin
            next_count = count + PDIV_ONE;
            if (count == (divSafe >> 1) - PDIV_ONE) begin
               next_divClk = 1'b0;
            end
         end
      end
      if (!enable) begin
         next_refOut = 1'b0;
      end else if (bypass) begin
         next_refOut = polIn;
      end else begin
         next_refOut = divClk;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prevIn <= 1'b0;
         count <= PDIV_ZERO;
         divClk <= 1'b0;
         refOut <= 1'b0;
      end else begin
         prevIn <= next_prevIn;
         count <= next_count;
         divClk <= next_divClk;
         refOut <= next_refOut;
      end
   end
endmodule

/* File: rtl/risc_ref_input_cfg.sv */
// Reference input stage configuration and system PLL setup logic.
// Assumes host writes arrive as single-cycle strobes; boot sources present a ready image.
`timescale 1ns/10ps
module risc_ref_input_cfg
   import risc_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   // Per-stage pins and GPIO0/GPIO3 reference inputs
   input wire logic [NUM_STAGES-1:0] stagePosPin,
   input wire logic [NUM_STAGES-1:0] stageNegPin,
   input wire logic gpio0RefIn,
   input wire logic gpio3RefIn,
   // Per-stage configuration
   input wire logic [2*NUM_STAGES-1:0] stageMode,
   input wire logic [NUM_STAGES-1:0] stageNmos,
   // Per internal clock configuration
   input wire logic [NUM_CLKS-1:0] clkEnable,
   input wire logic [NUM_CLKS-1:0] clkInvert,
   input wire logic [NUM_CLKS-1:0] clkBypass,
   input wire logic [NUM_CLKS*PDIV_W-1:0] clkDivValue,
   input wire logic [NUM_CLKS-1:0] clkIsPulse,
   // Nominal frequency programming
   input wire logic freqWrite,
   input wire logic [IDX_W-1:0] freqIndex,
   input wire logic [FREQ_M_W-1:0] freqNum,
   input wire logic [FREQ_N_W-1:0] freqDen,
   input wire logic [IDX_W-1:0] freqReadIndex,
   output logic [FREQ_M_W-1:0] freqNumRead,
   output logic [FREQ_N_W-1:0] freqDenRead,
   output logic [NUM_CLKS-1:0] freqProgrammed,
   // Boot sources
   input wire logic otpEnable,
   input wire logic otpValid,
   input wire logic [FBDIV_W-1:0] otpFbDiv,
   input wire logic otpDoubler,
   input wire logic eepromEnable,
   input wire logic eepromValid,
   input wire logic [FBDIV_W-1:0] eepromFbDiv,
   input wire logic eepromDoubler,
   // Host PLL writes, loop control voltage and alarm pin enable
   input wire logic pllWrite,
   input wire logic [FBDIV_W-1:0] pllFbDivIn,
   input wire logic pllDoublerIn,
   input wire logic [VCV_W-1:0] ctrlVoltage,
   input wire logic lolGpioEnable,
   // Outputs
   output logic [FBDIV_W-1:0] pllFbDiv,
   output logic pllDoubler,
   output logic pllWriteRejected,
   output logic bootDone,
   output logic lossOfLock,
   output logic lolGpio,
   output logic [NUM_CLKS-1:0] stageNmosActive,
   output logic [NUM_CLKS-1:0] refClk,
   output logic [NUM_CLKS-1:0] pulseOut
);
   risc_state_e state;
   risc_state_e next_state;
   logic [2:0] loadCnt;
   logic [2:0] next_loadCnt;
   logic [FBDIV_W-1:0] next_pllFbDiv;
   logic next_pllDoubler;
   logic next_pllWriteRejected;
   logic next_bootDone;
   logic [FREQ_M_W-1:0] freqNumMem [NUM_CLKS];
   logic [FREQ_N_W-1:0] freqDenMem [NUM_CLKS];
   logic [FREQ_M_W-1:0] next_freqNumRead;
   logic [FREQ_N_W-1:0] next_freqDenRead;
   logic [NUM_CLKS-1:0] next_freqProgrammed;
   logic [NUM_CLKS-1:0] pathIn;
   logic [NUM_CLKS-1:0] pathEn;
   logic [NUM_CLKS-1:0] pathBypass;
   logic [NUM_CLKS-1:0] pathOut;
   logic [NUM_CLKS-1:0] next_refClk;
   logic [NUM_CLKS-1:0] next_pulseOut;
   logic [NUM_CLKS-1:0] next_stageNmosActive;
   logic next_lolGpio;
   logic monLol;
   logic bootHit;
   logic [FBDIV_W-1:0] bootFbDiv;
   logic bootDoubler;

   ////////////////////////////////////////////////////////////////////////
   // Input routing to internal clock indices
   always_comb begin
      pathIn = '0;
      pathEn = '0;
      pathBypass = clkBypass;
      next_stageNmosActive = '0;
      for (int s = 0; s < NUM_STAGES; s++) begin
         case (risc_mode_e'(stageMode[2*s +: 2]))
            RISC_MODE_DIFF: begin
               pathIn[s] = stagePosPin[s] & ~stageNegPin[s];
               pathEn[s] = clkEnable[s];
               next_stageNmosActive[s] = stageNmos[s];
            end
            RISC_MODE_DUAL_SE: begin
               pathIn[s] = stagePosPin[s];
               pathEn[s] = clkEnable[s];
               pathIn[s+NEG_OFFSET] = stageNegPin[s];
               pathEn[s+NEG_OFFSET] = clkEnable[s+NEG_OFFSET];
            end
            RISC_MODE_DIFF_GPIO: begin
               pathIn[s] = stagePosPin[s] & ~stageNegPin[s];
               pathEn[s] = clkEnable[s];
               next_stageNmosActive[s] = stageNmos[s];
               if (s == GPIO0_STAGE) begin
                  pathIn[GPIO0_CLK] = gpio0RefIn;
                  pathEn[GPIO0_CLK] = clkEnable[GPIO0_CLK];
                  pathBypass[GPIO0_CLK] = 1'b1;
               end
            end
            default: begin
               pathIn[s] = 1'b0;
            end
         endcase
      end
      // No stage owns clock 15, so GPIO3 drives it directly when enabled
      pathIn[GPIO3_CLK] = gpio3RefIn;
      pathEn[GPIO3_CLK] = clkEnable[GPIO3_CLK];
      pathBypass[GPIO3_CLK] = 1'b1;
   end

   for (genvar c = 0; c < NUM_CLKS; c++) begin : gPath
      risc_pre_div uPreDiv (
         .core_clk(core_clk),
         .arst_n(arst_n),
         .refIn(pathIn[c]),
         .enable(pathEn[c]),
         .invert(clkInvert[c]),
         .bypass(pathBypass[c]),
         .divValue(clkDivValue[c*PDIV_W +: PDIV_W]),
         .refOut(pathOut[c])
      );
   end

   always_comb begin
      next_refClk = pathOut & ~clkIsPulse;
      next_pulseOut = pathOut & clkIsPulse;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         refClk <= '0;
         pulseOut <= '0;
         stageNmosActive <= '0;
      end else begin
         refClk <= next_refClk;
         pulseOut <= next_pulseOut;
         stageNmosActive <= next_stageNmosActive;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Nominal frequency store, M over N
   always_comb begin
      next_freqProgrammed = freqProgrammed;
      if (freqWrite) begin
         next_freqProgrammed[freqIndex] = 1'b1;
      end
      next_freqNumRead = freqNumMem[freqReadIndex];
      next_freqDenRead = freqDenMem[freqReadIndex];
   end

   // Store has no reset; freqProgrammed tells which entries hold data
   always_ff @(posedge core_clk) begin
      if (freqWrite) begin
         freqNumMem[freqIndex] <= freqNum;
         freqDenMem[freqIndex] <= freqDen;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         freqProgrammed <= '0;
         freqNumRead <= '0;
         freqDenRead <= '0;
      end else begin
         freqProgrammed <= next_freqProgrammed;
         freqNumRead <= next_freqNumRead;
         freqDenRead <= next_freqDenRead;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // PLL configuration load and host access
   // OTP takes precedence when both hold valid images
   always_comb begin
      bootHit = 1'b0;
      bootFbDiv = otpFbDiv;
      bootDoubler = otpDoubler;
      if (otpEnable && otpValid) begin
         bootHit = 1'b1;
      end else if (eepromEnable && eepromValid) begin
         bootHit = 1'b1;
         bootFbDiv = eepromFbDiv;
         bootDoubler = eepromDoubler;
      end
   end

   // Writes before bootDone are dropped, not queued
   always_comb begin
      next_state = state;
      next_loadCnt = loadCnt;
      next_pllFbDiv = pllFbDiv;
      next_pllDoubler = pllDoubler;
      next_pllWriteRejected = 1'b0;
      next_bootDone = bootDone;
      case (state)
         RISC_ST_IDLE: begin
            next_state = RISC_ST_LOAD;
            next_loadCnt = LOAD_CNT_W0;
         end
         RISC_ST_LOAD: begin
            next_loadCnt = loadCnt + 3'h1;
            if (loadCnt == 3'(LOAD_STEPS - 1)) begin
               next_state = RISC_ST_DONE;
               // No valid image keeps the reset values
               if (bootHit) begin
                  next_pllFbDiv = bootFbDiv;
                  next_pllDoubler = bootDoubler;
               end
            end
         end
         RISC_ST_DONE: begin
            next_bootDone = 1'b1;
            next_state = RISC_ST_RUN;
         end
         RISC_ST_RUN: begin
            if (pllWrite) begin
               if (pllFbDivIn >= FBDIV_MIN && pllFbDivIn <= FBDIV_MAX) begin
                  next_pllFbDiv = pllFbDivIn;
                  next_pllDoubler = pllDoublerIn;
               end else begin
                  next_pllWriteRejected = 1'b1;
               end
            end
         end
         default: begin
            next_state = RISC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= RISC_ST_IDLE;
         loadCnt <= LOAD_CNT_W0;
         pllFbDiv <= FBDIV_RESET;
         pllDoubler <= 1'b0;
         pllWriteRejected <= 1'b0;
         bootDone <= 1'b0;
      end else begin
         state <= next_state;
         loadCnt <= next_loadCnt;
         pllFbDiv <= next_pllFbDiv;
         pllDoubler <= next_pllDoubler;
         pllWriteRejected <= next_pllWriteRejected;
         bootDone <= next_bootDone;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lock alarm and its optional pin
   risc_lock_mon uLockMon (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .ctrlVoltage(ctrlVoltage),
      .fbDiv(pllFbDiv),
      .doubler(pllDoubler),
      .lossOfLock(monLol)
   );

   assign lossOfLock = monLol;

   always_comb begin
      next_lolGpio = lolGpioEnable & monLol;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         lolGpio <= 1'b0;
      end else begin
         lolGpio <= next_lolGpio;
      end
   end
endmodule
